// File: common/adc_conv_pkg.sv
// constants shared by the converter control block
//
// Functional notes
// - ref_select picks external reference or supply
// - port_analog_cfg bits: 1 analog, reset ones
// - fourth pin bit reads zero unless port
// - acq_time_sel codes give 0..20 conversion periods
// - internal RC clock starts one instruction later
// - only internal RC clock converts in sleep
// - successive approximation on held sample
// - reset restores control defaults, aborts any conversion
// - done loads result, clears go, sets flag
// - reset leaves result pair untouched
// - two periods pass before sampling resumes
// - conversion takes eleven periods
// - code 000 converts at once, sampling stops
// - go reads busy; converter_on gates module
// - channel_select routes input 0..3
package adc_conv_pkg;
	localparam int          ADDR_W        = 5;
	localparam logic [4:0]  OFS_CTRL      = 5'h00;
	localparam logic [4:0]  OFS_PIN_CFG   = 5'h04;
	localparam logic [4:0]  OFS_TIM_CFG   = 5'h08;
	localparam logic [4:0]  OFS_RES_HIGH  = 5'h0C;
	localparam logic [4:0]  OFS_RES_LOW   = 5'h10;
	localparam logic [4:0]  OFS_STATUS    = 5'h14;
	// control word fields
	localparam int          CTRL_ON_BIT   = 0;
	localparam int          CTRL_GO_BIT   = 1;
	localparam int          CTRL_CHAN_LSB = 2;
	// pin and reference fields
	localparam int          PIN_REF_BIT   = 4;
	localparam logic [7:0]  PIN_CFG_RST   = 8'h0F;
	// timing and format fields
	localparam int          TIM_JUST_BIT  = 7;
	localparam int          TIM_ACQ_LSB   = 3;
	localparam logic [7:0]  TIM_CFG_RST   = 8'h00;
	localparam logic [2:0]  CLK_SEL_RC    = 3'h7;
	localparam int          STAT_DONE_BIT = 0;
	localparam int          RES_W         = 10;
	// acquisition length in conversion periods per acq_time_sel code
	localparam logic [4:0]  ACQ_TADS_TAB [0:7] = '{5'h00, 5'h02,
		5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h14};
	localparam logic [4:0]  GAP_TADS      = 5'h02;
	localparam int          CONV_TADS     = 11;
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          INSTR_CYCLE_NS = 200;
	localparam int          INSTR_CYCLE_CYC =
		(INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// File: hw/tad_gen.sv
// conversion period tick generator
`timescale 1ns/100ps
`default_nettype none
module tad_gen
	import adc_conv_pkg::*;
#(
	parameter int CNT_W = 6
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             run_i,
	input  wire logic             sleep_i,
	input  wire logic             rc_tick_i,
	input  wire logic [2:0]       sel_i,
	output logic                  tad_tick_o
);
	if (CNT_W < 6) begin : g_chk
		$error("tad_gen: CNT_W must hold a divide by 64");
	end

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic [CNT_W-1:0] last;
	logic             rc_sel;

	always_comb begin
		rc_sel = (sel_i[1:0] == CLK_SEL_RC[1:0]);
		case (sel_i)
			3'h0: last = CNT_W'(1);
			3'h4: last = CNT_W'(3);
			3'h1: last = CNT_W'(7);
			3'h5: last = CNT_W'(15);
			3'h2: last = CNT_W'(31);
			3'h6: last = CNT_W'(63);
			default: last = '0;
		endcase
		// oscillator-derived periods stop in sleep, RC keeps running
		if (rc_sel) begin
			tad_tick_o = run_i && rc_tick_i;
		end else begin
			tad_tick_o = run_i && !sleep_i && (cnt_reg == last);
		end
		if (!run_i || tad_tick_o) begin
			cnt_next = '0;
		end else if (rc_sel || sleep_i) begin
			cnt_next = cnt_reg;
		end else begin
			cnt_next = cnt_reg + CNT_W'(1);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	a_sleep_stops: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		sleep_i && (sel_i[1:0] != 2'h3) |-> !tad_tick_o)
		else $error("conversion period ticked in sleep");
endmodule
`default_nettype wire

// File: hw/sar_core.sv
// successive approximation register
`timescale 1ns/100ps
`default_nettype none
module sar_core
	import adc_conv_pkg::*;
#(
	parameter int WIDTH = RES_W
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             start_i,
	input  wire logic             abort_i,
	input  wire logic             tad_i,
	input  wire logic             comp_i,
	output logic                  busy_o,
	output logic                  done_o,
	output logic [WIDTH-1:0]      trial_o
);
	if (WIDTH < 2 || WIDTH > 14) begin : g_chk
		$error("sar_core: WIDTH out of range");
	end

	localparam logic [WIDTH-1:0] MSB = {1'b1, {(WIDTH-1){1'b0}}};

	logic             busy_reg, busy_next;
	logic             first_reg, first_next;
	logic             done_reg, done_next;
	logic [WIDTH-1:0] mask_reg, mask_next;
	logic [WIDTH-1:0] approx_reg, approx_next;
	logic [4:0]       tcnt_reg, tcnt_next;

	// comp_i high means held input is at or above the trial code
	always_comb begin
		busy_next   = busy_reg;
		first_next  = first_reg;
		mask_next   = mask_reg;
		approx_next = approx_reg;
		done_next   = 1'b0;
		tcnt_next   = tcnt_reg;
		if (abort_i) begin
			busy_next = 1'b0;
		end else if (start_i && !busy_reg) begin
			busy_next   = 1'b1;
			first_next  = 1'b1;
			mask_next   = '0;
			approx_next = '0;
			tcnt_next   = '0;
		end else if (busy_reg && tad_i) begin
			tcnt_next = tcnt_reg + 5'h01;
			// first period settles the hold, then one bit per period
			if (first_reg) begin
				first_next  = 1'b0;
				mask_next   = MSB;
				approx_next = MSB;
			end else begin
				approx_next = comp_i ? approx_reg : (approx_reg & ~mask_reg);
				mask_next   = mask_reg >> 1;
				approx_next = approx_next | mask_next;
				if (mask_reg[0]) begin
					busy_next = 1'b0;
					done_next = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			busy_reg   <= 1'b0;
			first_reg  <= 1'b0;
			done_reg   <= 1'b0;
			mask_reg   <= '0;
			approx_reg <= '0;
			tcnt_reg   <= '0;
		end else begin
			busy_reg   <= busy_next;
			first_reg  <= first_next;
			done_reg   <= done_next;
			mask_reg   <= mask_next;
			approx_reg <= approx_next;
			tcnt_reg   <= tcnt_next;
		end
	end

	assign busy_o  = busy_reg;
	assign done_o  = done_reg;
	assign trial_o = approx_reg;

	a_eleven_periods: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		done_reg |-> tcnt_reg == 5'(WIDTH + 1))
		else $error("conversion did not take eleven periods");
endmodule
`default_nettype wire

// File: hw/adc_conv_ctrl.sv
// converter control: register slave, sequencer and result format
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module adc_conv_ctrl
	import adc_conv_pkg::*;
(
	input  wire logic              sys_clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	input  wire logic              sleep_i,
	input  wire logic              rc_tick_i,
	input  wire logic              comp_i,
	input  wire logic              pin3_port_i,
	output logic                   converter_on_o,
	output logic                   ref_select_o,
	output logic [3:0]             port_analog_o,
	output logic [1:0]             channel_select_o,
	output logic                   sample_o,
	output logic [RES_W-1:0]       dac_code_o,
	output logic                   conv_done_flag_o
);
	typedef enum logic [2:0] {
		ST_SAMPLE, ST_RCDLY, ST_ACQ, ST_CONV, ST_GAP
	} seq_state_t;

	// ****************************************
	// register bus slave
	// ****************************************
	logic              aw_have_reg, aw_have_next;
	logic              w_have_reg, w_have_next;
	logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [7:0]        wdata_reg, wdata_next;
	logic              wstrb_reg, wstrb_next;
	logic              bvalid_reg, bvalid_next;
	logic [1:0]        bresp_reg, bresp_next;
	logic              rvalid_reg, rvalid_next;
	logic [7:0]        rdata_reg, rdata_next;
	logic [1:0]        rresp_reg, rresp_next;
	logic              wr_en;
	logic              wr_hit;
	logic              rd_hit;
	logic [7:0]        rd_val;

	logic [7:0]        ctrl_rd, pin_rd, tim_reg, pin_reg;
	logic [15:0]       res_reg;
	logic              on_reg, go_reg, flag_reg;
	logic [1:0]        chan_reg;

	always_comb begin
		ctrl_rd = {4'h0, chan_reg, go_reg, on_reg};
		// fourth pin bit is hidden when that pin is not a port pin
		pin_rd = {3'h0, pin_reg[PIN_REF_BIT],
			pin_reg[3] & pin3_port_i, pin_reg[2:0]};
		rd_hit = 1'b1;
		case (s_axi_araddr)
			OFS_CTRL:     rd_val = ctrl_rd;
			OFS_PIN_CFG:  rd_val = pin_rd;
			OFS_TIM_CFG:  rd_val = {tim_reg[7], 1'b0, tim_reg[5:0]};
			OFS_RES_HIGH: rd_val = res_reg[15:8];
			OFS_RES_LOW:  rd_val = res_reg[7:0];
			OFS_STATUS:   rd_val = {7'h00, flag_reg};
			default: begin
				rd_val = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
		case (awaddr_reg)
			OFS_CTRL, OFS_PIN_CFG, OFS_TIM_CFG, OFS_STATUS: wr_hit = 1'b1;
			OFS_RES_HIGH, OFS_RES_LOW: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
		aw_have_next = aw_have_reg;
		w_have_next  = w_have_reg;
		awaddr_next  = awaddr_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		s_axi_awready = !aw_have_reg && !bvalid_reg;
		s_axi_wready  = !w_have_reg && !bvalid_reg;
		s_axi_arready = !rvalid_reg;
		wr_en = aw_have_reg && w_have_reg && !bvalid_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_next = 1'b1;
			awaddr_next  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_next = 1'b1;
			wdata_next  = s_axi_wdata[7:0];
			wstrb_next  = s_axi_wstrb[0];
		end
		if (wr_en) begin
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rdata_next  = rd_val;
			rresp_next  = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			awaddr_reg  <= '0;
			wdata_reg   <= 8'h00;
			wstrb_reg   <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 8'h00;
			rresp_reg   <= RESP_OKAY;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg  <= w_have_next;
			awaddr_reg  <= awaddr_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = {24'h000000, rdata_reg};
	assign s_axi_rresp  = rresp_reg;

	// ****************************************
	// configuration and conversion sequencer
	// ****************************************
	seq_state_t  st_reg, st_next;
	logic [4:0]  cnt_reg, cnt_next;
	logic        on_next, go_next, flag_next;
	logic [1:0]  chan_next;
	logic [7:0]  pin_next, tim_next;
	logic [15:0] res_next;
	logic        rc_sel, tad_tick, tad_run;
	logic        sar_start, sar_abort, sar_done;
	logic [4:0]  acq_tads;
	logic [RES_W-1:0] sar_val;
	logic        wr_ok;

	always_comb begin
		wr_ok     = wr_en && wstrb_reg;
		rc_sel    = (tim_reg[1:0] == CLK_SEL_RC[1:0]);
		acq_tads  = ACQ_TADS_TAB[tim_reg[TIM_ACQ_LSB +: 3]];
		st_next   = st_reg;
		cnt_next  = cnt_reg;
		on_next   = on_reg;
		go_next   = go_reg;
		flag_next = flag_reg;
		chan_next = chan_reg;
		pin_next  = pin_reg;
		tim_next  = tim_reg;
		res_next  = res_reg;
		sar_start = 1'b0;
		sar_abort = 1'b0;
		if (wr_ok && awaddr_reg == OFS_CTRL) begin
			on_next   = wdata_reg[CTRL_ON_BIT];
			chan_next = wdata_reg[CTRL_CHAN_LSB +: 2];
			if (wdata_reg[CTRL_GO_BIT]) begin
				go_next = 1'b1;
			end
		end
		if (wr_ok && awaddr_reg == OFS_PIN_CFG) begin
			pin_next = {3'h0, wdata_reg[4:0]};
		end
		if (wr_ok && awaddr_reg == OFS_TIM_CFG) begin
			tim_next = {wdata_reg[7], 1'b0, wdata_reg[5:0]};
		end
		if (wr_ok && awaddr_reg == OFS_STATUS && wdata_reg[STAT_DONE_BIT]) begin
			flag_next = 1'b0;
		end
		case (st_reg)
			ST_SAMPLE: begin
				cnt_next = '0;
				if (go_reg) begin
					if (rc_sel) begin
						st_next = ST_RCDLY;
					end else if (acq_tads == 5'h00) begin
						st_next   = ST_CONV;
						sar_start = 1'b1;
					end else begin
						st_next = ST_ACQ;
					end
				end
			end
			ST_RCDLY: begin
				if (cnt_reg == 5'(INSTR_CYCLE_CYC - 1)) begin
					cnt_next = '0;
					if (acq_tads == 5'h00) begin
						st_next   = ST_CONV;
						sar_start = 1'b1;
					end else begin
						st_next = ST_ACQ;
					end
				end else begin
					cnt_next = cnt_reg + 5'h01;
				end
			end
			ST_ACQ: begin
				if (tad_tick) begin
					if (cnt_reg == acq_tads - 5'h01) begin
						cnt_next  = '0;
						st_next   = ST_CONV;
						sar_start = 1'b1;
					end else begin
						cnt_next = cnt_reg + 5'h01;
					end
				end
			end
			ST_CONV: begin
				if (sar_done) begin
					st_next   = ST_GAP;
					cnt_next  = '0;
					go_next   = 1'b0;
					flag_next = 1'b1;
					// result follows the justification in force at the end
					if (tim_reg[TIM_JUST_BIT]) begin
						res_next = {6'h00, sar_val};
					end else begin
						res_next = {sar_val, 6'h00};
					end
				end
			end
			ST_GAP: begin
				if (tad_tick) begin
					if (cnt_reg == GAP_TADS - 5'h01) begin
						st_next = ST_SAMPLE;
					end else begin
						cnt_next = cnt_reg + 5'h01;
					end
				end
			end
			default: st_next = ST_SAMPLE;
		endcase
		// turning the module off drops whatever is in flight
		if (!on_next) begin
			st_next   = ST_SAMPLE;
			go_next   = 1'b0;
			sar_abort = 1'b1;
			sar_start = 1'b0;
		end
		tad_run = (st_reg == ST_ACQ) || (st_reg == ST_CONV) ||
			(st_reg == ST_GAP);
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			st_reg   <= ST_SAMPLE;
			cnt_reg  <= '0;
			on_reg   <= 1'b0;
			go_reg   <= 1'b0;
			flag_reg <= 1'b0;
			chan_reg <= 2'h0;
			pin_reg  <= PIN_CFG_RST;
			tim_reg  <= TIM_CFG_RST;
		end else begin
			st_reg   <= st_next;
			cnt_reg  <= cnt_next;
			on_reg   <= on_next;
			go_reg   <= go_next;
			flag_reg <= flag_next;
			chan_reg <= chan_next;
			pin_reg  <= pin_next;
			tim_reg  <= tim_next;
		end
	end

	// result pair is deliberately outside reset
	always_ff @(posedge sys_clk_i) begin
		res_reg <= res_next;
	end

	tad_gen u_tad (
		.sys_clk_i  (sys_clk_i),
		.rst_n_i    (rst_n_i),
		.run_i      (tad_run),
		.sleep_i    (sleep_i),
		.rc_tick_i  (rc_tick_i),
		.sel_i      (tim_reg[2:0]),
		.tad_tick_o (tad_tick)
	);

	sar_core #(.WIDTH(RES_W)) u_sar (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.start_i   (sar_start),
		.abort_i   (sar_abort),
		.tad_i     (tad_tick),
		.comp_i    (comp_i),
		.busy_o    (),
		.done_o    (sar_done),
		.trial_o   (sar_val)
	);

	assign converter_on_o   = on_reg;
	assign ref_select_o     = pin_reg[PIN_REF_BIT];
	assign port_analog_o    = {pin_reg[3] & pin3_port_i, pin_reg[2:0]};
	assign channel_select_o = chan_reg;
	assign dac_code_o       = sar_val;
	assign conv_done_flag_o = flag_reg;
	// hold switch opens once go is taken with no automatic acquisition
	assign sample_o = on_reg && ((st_reg == ST_SAMPLE) || (st_reg == ST_ACQ) ||
		(st_reg == ST_RCDLY && acq_tads != 5'h00));

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_done_clears_go: assert property (sar_done |=> !go_reg && flag_reg)
		else $error("done did not clear go or set flag");
	a_reset_state: assert property (disable iff (1'b0)
		!rst_n_i |=> !on_reg && !go_reg && pin_reg == PIN_CFG_RST)
		else $error("reset values wrong");
	a_pin3_hidden: assert property (!pin3_port_i |-> !pin_rd[3] && !port_analog_o[3])
		else $error("fourth pin bit visible");
	a_rc_delay: assert property (disable iff (!rst_n_i || !on_reg)
		$rose(st_reg == ST_RCDLY) |-> (st_reg == ST_RCDLY)[*4] ##1 st_reg != ST_RCDLY)
		else $error("internal clock start delay wrong");
	a_acq_zero: assert property (st_reg == ST_SAMPLE && go_reg && on_next &&
		!rc_sel && acq_tads == 5'h00 |=> st_reg == ST_CONV && !sample_o)
		else $error("no immediate conversion");
	a_gap_hold: assert property (sar_done && on_reg |=> !sample_o [*3])
		else $error("sampling resumed too early");
	a_just_right: assert property (sar_done && tim_reg[TIM_JUST_BIT]
		|=> res_reg[15:10] == 6'h00 && res_reg[9:0] == $past(sar_val))
		else $error("right justified result wrong");
	a_go_reads_busy: assert property (st_reg == ST_CONV |-> go_reg && on_reg)
		else $error("go clear during conversion");

	c_conv_done:  cover property (sar_done);
	c_auto_acq:   cover property (st_reg == ST_ACQ ##1 st_reg == ST_CONV);
	c_rc_start:   cover property (st_reg == ST_RCDLY);
	c_off_abort:  cover property (st_reg == ST_CONV ##1 !on_reg);
endmodule
`default_nettype wire

// File: verif/adc_analog_model.sv
// far-side model: four analog inputs, sample-and-hold, comparator
`timescale 1ns/100ps
`default_nettype none
module adc_analog_model
	import adc_conv_pkg::*;
#(
	// pins only ever feed the hold, so they stay inputs
	parameter logic [39:0] VIN = 40'h0
) (
	input  wire logic             sys_clk_i,
	input  wire logic [1:0]       chan_i,
	input  wire logic             sample_i,
	input  wire logic [RES_W-1:0] code_i,
	output logic                  comp_o
);
	logic [RES_W-1:0] held_reg = '0;
	// hold only tracks while the switch is closed
	always @(posedge sys_clk_i) begin
		if (sample_i) begin
			held_reg <= VIN[chan_i*10 +: 10];
		end
	end
	assign comp_o = (held_reg >= code_i);
endmodule
`default_nettype wire

// File: verif/adc_conv_ctrl_test.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module adc_conv_ctrl_test
	import adc_conv_pkg::*;
;
	localparam logic [39:0] V = {10'h3FF, 10'h301, 10'h0FF, 10'h2B5};
	// system clocks per period for each clock select code, 3 is the RC
	localparam int          PER [0:6] = '{2, 8, 32, 0, 4, 16, 64};
	typedef struct packed {
		logic [4:0] a;
		logic       w;
		logic [7:0] d;
		logic [7:0] e;
		logic [1:0] r;
	} row_t;
	logic sys_clk_i = 0, rst_n_i = 0, sleep_i = 0, rc_tick_i = 0;
	logic pin3_port_i = 1, comp_i;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, converter_on_o, ref_select_o, sample_o;
	logic conv_done_flag_o;
	logic [1:0] s_axi_bresp, s_axi_rresp, channel_select_o;
	logic [31:0] s_axi_rdata;
	logic [3:0] port_analog_o;
	logic [9:0] dac_code_o;
	int num_errors = 0, cmp_count = 0, cyc = 0, rc_cnt = 0;
	logic [31:0] d, h0;
	logic [1:0] r;
	row_t rows [0:6] = '{
		'{OFS_CTRL, 1'b0, 8'h00, 8'h00, RESP_OKAY},
		'{OFS_PIN_CFG, 1'b0, 8'h00, 8'h0F, RESP_OKAY},
		'{OFS_TIM_CFG, 1'b0, 8'h00, 8'h00, RESP_OKAY},
		'{OFS_STATUS, 1'b0, 8'h00, 8'h00, RESP_OKAY},
		'{OFS_PIN_CFG, 1'b1, 8'hFA, 8'h1A, RESP_OKAY},
		'{OFS_TIM_CFG, 1'b1, 8'hFF, 8'hBF, RESP_OKAY},
		'{5'h18, 1'b1, 8'h55, 8'h00, RESP_SLVERR}};

	adc_conv_ctrl DUT (.*);
	adc_analog_model #(.VIN(V)) model (.sys_clk_i(sys_clk_i),
		.chan_i(channel_select_o), .sample_i(sample_o),
		.code_i(dac_code_o), .comp_o(comp_i));

	always #25 sys_clk_i = ~sys_clk_i;
	// free-running stand-in for the internal RC oscillator
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
		rc_tick_i <= (rc_cnt == 4);
	end

	// ****************
	// bus tasks
	// ****************
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", nm, e, g);
			num_errors++;
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		logic at, wt, bt;
		@(posedge sys_clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(negedge sys_clk_i);
			at = s_axi_awvalid & s_axi_awready;
			wt = s_axi_wvalid & s_axi_wready;
			bt = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge sys_clk_i);
			if (at) s_axi_awvalid <= 1'b0;
			if (wt) s_axi_wvalid <= 1'b0;
			if (bt) begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [4:0] a);
		logic at, rt;
		@(posedge sys_clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(negedge sys_clk_i);
			at = s_axi_arvalid & s_axi_arready;
			rt = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge sys_clk_i);
			if (at) s_axi_arvalid <= 1'b0;
			if (rt) begin
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask

	// one conversion: p sys cycles per period, x extra start delay
	task automatic conv(input logic [1:0] ch, input logic [7:0] tim,
		input int p, input int x);
		int t0, n, e;
		logic [9:0] v;
		v = V[ch*10 +: 10];
		e = (int'(ACQ_TADS_TAB[tim[5:3]]) + 11) * p + x;
		wr(OFS_TIM_CFG, tim);
		wr(OFS_CTRL, {4'h0, ch, 2'b01});
		repeat (4) @(posedge sys_clk_i);
		wr(OFS_CTRL, {4'h0, ch, 2'b11});
		t0 = cyc;
		rd(OFS_CTRL);
		chk("go_busy", 32'h1, 32'(d[1]));
		for (n = 0; n < 3000 && conv_done_flag_o !== 1'b1; n++)
			@(negedge sys_clk_i);
		n = cyc - t0;
		chk("conv_time", 32'h1, 32'(n >= e - 3 && n <= e + 2*p + 4));
		chk("gap_hold", 32'h0, 32'(sample_o));
		rd(OFS_CTRL);
		chk("go_clear", {28'h0, ch, 2'b01}, d);
		rd(OFS_STATUS);
		chk("done_flag", 32'h1, d);
		rd(OFS_RES_HIGH);
		chk("res_hi", tim[7] ? {30'h0, v[9:8]} : {24'h0, v[9:2]}, d);
		rd(OFS_RES_LOW);
		chk("res_lo", tim[7] ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h0}, d);
		for (n = 0; n < 200 && sample_o !== 1'b1; n++)
			@(negedge sys_clk_i);
		chk("resample", 32'h1, 32'(sample_o));
		wr(OFS_STATUS, 8'h01);
		chk("flag_clr", 32'h0, 32'(conv_done_flag_o));
	endtask

	task automatic stop_test;
		if (num_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ****************
	// main sequence
	// ****************
	initial begin
		repeat (2) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr(rows[i].a, rows[i].d);
				chk("bresp", 32'(rows[i].r), 32'(r));
			end
			rd(rows[i].a);
			chk("rdata", 32'(rows[i].e), d);
			chk("rresp", 32'(rows[i].r), 32'(r));
		end
		chk("ref_sel", 32'h1, 32'(ref_select_o));
		pin3_port_i <= 1'b0;
		rd(OFS_PIN_CFG);
		chk("pin_cfg_hid", 32'h12, d);
		chk("port_analog", 32'h2, 32'(port_analog_o));
		pin3_port_i <= 1'b1;
		for (int k = 0; k < 8; k++)
			conv(k[1:0], {k[0], 1'b0, k[2:0], 3'h0}, 2, 0);
		for (int k = 1; k < 7; k++)
			if (k != 3) conv(k[1:0], 8'(k), PER[k], 0);
		sleep_i <= 1'b1;
		conv(2'h3, 8'h87, 5, 4);
		wr(OFS_TIM_CFG, 8'h00);
		wr(OFS_CTRL, 8'h03);
		repeat (100) @(negedge sys_clk_i);
		chk("sleep_stall", 32'h0, 32'(conv_done_flag_o));
		@(posedge sys_clk_i);
		sleep_i <= 1'b0;
		repeat (100) @(negedge sys_clk_i);
		chk("wake_done", 32'h1, 32'(conv_done_flag_o));
		rd(OFS_RES_HIGH);
		h0 = d;
		wr(OFS_STATUS, 8'h01);
		wr(OFS_CTRL, 8'h03);
		wr(OFS_CTRL, 8'h00);
		repeat (100) @(negedge sys_clk_i);
		chk("off_abort", 32'h0, 32'(conv_done_flag_o));
		wr(OFS_TIM_CFG, 8'h38);
		wr(OFS_CTRL, 8'h03);
		repeat (20) @(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (100) @(negedge sys_clk_i);
		chk("abort_flag", 32'h0, 32'(conv_done_flag_o));
		chk("rst_on", 32'h0, 32'(converter_on_o));
		chk("rst_port", 32'hF, 32'(port_analog_o));
		rd(OFS_CTRL);
		chk("rst_ctrl", 32'h0, d);
		rd(OFS_RES_HIGH);
		chk("res_kept", h0, d);
		stop_test();
	end

	initial begin
		#(50 * 40000);
		num_errors++;
		stop_test();
	end
endmodule
`default_nettype wire
